// ---- pkg/drl_cfg.svh ----
// constants of the divide-ratio serial load link: widths, frame lengths, offsets and timing
`ifndef DRL_CFG_SVH
`define DRL_CFG_SVH

// ratio field widths
`define DRL_REF_W 14
`define DRL_SWALLOW_W 6
`define DRL_MAIN_W 12
`define DRL_SR_W 18
`define DRL_RATIO_MIN 5

// frame lengths including the control bit
`define DRL_MAIN_FRAME_LEN 19
`define DRL_REF_FRAME_LEN 15

// control bit values
`define DRL_CTRL_REF 1'b1
`define DRL_CTRL_MAIN 1'b0

// main divider word layout in the shift register
`define DRL_SW_LSB 0
`define DRL_MAIN_LSB 6

// controller register word offsets (avalon word address)
`define DRL_REG_REF 2'h0
`define DRL_REG_MAIN 2'h1
`define DRL_REG_STATUS 2'h2

// status register bit positions
`define DRL_ST_BUSY 0
`define DRL_ST_REF_DONE 1
`define DRL_ST_MAIN_DONE 2
`define DRL_ST_ERR 3
`define DRL_ST_READY 4

// timing: every link figure is a 1 us minimum
`define DRL_CLK_PERIOD_NS 5
`define DRL_T_MIN_NS 1000
`define DRL_T_CYC ((`DRL_T_MIN_NS + `DRL_CLK_PERIOD_NS - 1) / `DRL_CLK_PERIOD_NS)
`define DRL_CNT_W 8

`endif

// ---- pkg/drl_pkg.sv ----
// types shared by both ends of the divide-ratio serial load link
package drl_pkg;
  `include "drl_cfg.svh"

  typedef logic [`DRL_REF_W-1:0] drl_ref_t;
  typedef logic [`DRL_SWALLOW_W-1:0] drl_swallow_t;
  typedef logic [`DRL_MAIN_W-1:0] drl_main_t;
  typedef logic [`DRL_MAIN_FRAME_LEN-1:0] drl_frame_t;

  // controller sequencer states
  typedef enum logic [2:0] {
    DRL_IDLE,
    DRL_SETUP,
    DRL_HIGH,
    DRL_STB_WAIT,
    DRL_STROBE,
    DRL_GAP
  } drl_host_st_e;
endpackage

// ---- pkg/drl_if.sv ----
// three-wire serial load link between controller and synthesizer
`timescale 1ns/1ps
interface drl_if;
  logic ser_data;
  logic ser_clk;
  logic latch_strobe;

  modport host (
    output ser_data,
    output ser_clk,
    output latch_strobe
  );

  modport dev (
    input ser_data,
    input ser_clk,
    input latch_strobe
  );
endinterface

// ---- verilog/drl_device.sv ----
// synthesizer end: shift register, control stage and the two divider latches
`timescale 1ns/1ps
module drl_device
  import drl_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // serial link
  drl_if.dev link,
  // divider contents
  output drl_ref_t reference_ratio_bits,
  output drl_swallow_t swallow_count_bits,
  output drl_main_t main_count_bits,
  // load state
  output logic ref_loaded,
  output logic main_loaded,
  output logic ref_ratio_ok
);

  logic [2:0] pin_raw;
  logic [2:0] sync1_q, sync1_d;
  logic [2:0] sync2_q, sync2_d;
  logic sclk_prev_q, sclk_prev_d;
  logic sclk_rise;
  logic [`DRL_SR_W-1:0] sr_q, sr_d;
  logic ctrl_q, ctrl_d;
  drl_ref_t ref_q, ref_d;
  drl_swallow_t sw_q, sw_d;
  drl_main_t main_q, main_d;
  logic ref_ld_q, ref_ld_d;
  logic main_ld_q, main_ld_d;

  // pins: 2 = data, 1 = serial clock, 0 = strobe
  assign pin_raw = {link.ser_data, link.ser_clk, link.latch_strobe};

  // two-stage synchronisers and clock edge finder
  always_comb begin
    sync1_d = pin_raw;
    sync2_d = sync1_q;
    sclk_prev_d = sync2_q[1];
  end

  assign sclk_rise = sync2_q[1] & ~sclk_prev_q;

  // shift path and divider latches
  always_comb begin
    sr_d = sr_q;
    ctrl_d = ctrl_q;
    ref_d = ref_q;
    sw_d = sw_q;
    main_d = main_q;
    ref_ld_d = ref_ld_q;
    main_ld_d = main_ld_q;
    // oldest bits fall off the top
    // newest bit sits in control stage
    if (sclk_rise) begin
      sr_d = {sr_q[`DRL_SR_W-2:0], ctrl_q};
      ctrl_d = sync2_q[2];
    end
    if (sync2_q[0]) begin
      if (ctrl_q == `DRL_CTRL_REF) begin
        ref_d = sr_q[`DRL_REF_W-1:0];
        ref_ld_d = 1'b1;
      end else begin
        sw_d = sr_q[`DRL_SW_LSB +: `DRL_SWALLOW_W];
        main_d = sr_q[`DRL_MAIN_LSB +: `DRL_MAIN_W];
        main_ld_d = 1'b1;
      end
    end
  end

  // register all state, frozen while clk_en is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sclk_prev_q <= 1'b0;
      sr_q <= 18'h00000;
      ctrl_q <= 1'b0;
      ref_q <= 14'h0000;
      sw_q <= 6'h00;
      main_q <= 12'h000;
      ref_ld_q <= 1'b0;
      main_ld_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sclk_prev_q <= sclk_prev_d;
      sr_q <= sr_d;
      ctrl_q <= ctrl_d;
      ref_q <= ref_d;
      sw_q <= sw_d;
      main_q <= main_d;
      ref_ld_q <= ref_ld_d;
      main_ld_q <= main_ld_d;
    end
  end

  // outputs
  assign reference_ratio_bits = ref_q;
  assign swallow_count_bits = sw_q;
  assign main_count_bits = main_q;
  assign ref_loaded = ref_ld_q;
  assign main_loaded = main_ld_q;
  assign ref_ratio_ok = (ref_q >= `DRL_REF_W'(`DRL_RATIO_MIN));

endmodule

// ---- verilog/drl_host.sv ----
// controller end: avalon register slave that drives frames onto the serial load link
`timescale 1ns/1ps
module drl_host
  import drl_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial link
  drl_if.host link
);

  localparam logic [`DRL_CNT_W-1:0] T_LAST = `DRL_CNT_W'(`DRL_T_CYC - 1);

  // main word is legal when count >= 5 and swallow < count
  function automatic logic main_ok(input drl_main_t n, input drl_swallow_t a);
    main_ok = (n >= `DRL_MAIN_W'(`DRL_RATIO_MIN)) && (`DRL_MAIN_W'(a) < n);
  endfunction

  // reference word is legal when ratio >= 5
  function automatic logic ref_ok(input drl_ref_t r);
    ref_ok = (r >= `DRL_REF_W'(`DRL_RATIO_MIN));
  endfunction

  drl_host_st_e st_q, st_d;
  logic [`DRL_CNT_W-1:0] cnt_q, cnt_d;
  drl_frame_t tx_q, tx_d;
  logic [4:0] bits_q, bits_d;
  logic tgt_q, tgt_d;
  logic sclk_q, sclk_d;
  logic stb_q, stb_d;
  drl_ref_t ref_q, ref_d;
  drl_swallow_t sw_q, sw_d;
  drl_main_t main_q, main_d;
  logic ref_done_q, ref_done_d;
  logic main_done_q, main_done_d;
  logic err_q, err_d;
  logic rd_ack_q, rd_ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_ref, wr_main, wr_frame, busy, cnt_end;
  drl_ref_t wr_r;
  drl_swallow_t wr_a;
  drl_main_t wr_n;

  // bus decode
  always_comb begin
    wr_ref = 1'b0;
    wr_main = 1'b0;
    if (avs_address == `DRL_REG_REF) begin
      wr_ref = avs_write;
    end else if (avs_address == `DRL_REG_MAIN) begin
      wr_main = avs_write;
    end
  end

  assign wr_frame = wr_ref | wr_main;
  assign busy = (st_q != DRL_IDLE);
  assign cnt_end = (cnt_q == T_LAST);
  assign wr_r = avs_writedata[`DRL_REF_W-1:0];
  assign wr_a = avs_writedata[`DRL_SW_LSB +: `DRL_SWALLOW_W];
  assign wr_n = avs_writedata[`DRL_MAIN_LSB +: `DRL_MAIN_W];

  // frame writes stall until the gap after the previous strobe is over
  assign avs_waitrequest = ~clk_en | (wr_frame & busy) | (avs_read & ~rd_ack_q);

  // frame sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    bits_d = bits_q;
    tgt_d = tgt_q;
    sclk_d = sclk_q;
    stb_d = stb_q;
    ref_d = ref_q;
    sw_d = sw_q;
    main_d = main_q;
    ref_done_d = ref_done_q;
    main_done_d = main_done_q;
    err_d = err_q;
    case (st_q)
      DRL_IDLE: begin
        cnt_d = '0;
        if (wr_ref) begin
          if (ref_ok(wr_r)) begin
            ref_d = wr_r;
            // reference frame ends with a one
            tx_d = {wr_r, `DRL_CTRL_REF, 4'h0};
            bits_d = 5'(`DRL_REF_FRAME_LEN);
            tgt_d = `DRL_CTRL_REF;
            err_d = 1'b0;
            st_d = DRL_SETUP;
          end else begin
            err_d = 1'b1;
          end
        end else if (wr_main) begin
          // refuse main below five or swallow too big
          if (main_ok(wr_n, wr_a)) begin
            sw_d = wr_a;
            main_d = wr_n;
            // main count first, then swallow, then zero
            tx_d = {wr_n, wr_a, `DRL_CTRL_MAIN};
            bits_d = 5'(`DRL_MAIN_FRAME_LEN);
            tgt_d = `DRL_CTRL_MAIN;
            err_d = 1'b0;
            st_d = DRL_SETUP;
          end else begin
            err_d = 1'b1;
          end
        end
      end
      DRL_SETUP: begin
        // data stands low-clock for the setup time
        cnt_d = cnt_q + 1'b1;
        if (cnt_end) begin
          cnt_d = '0;
          // device samples on this rising edge
          sclk_d = 1'b1;
          st_d = DRL_HIGH;
        end
      end
      DRL_HIGH: begin
        // high phase covers pulse width and hold
        cnt_d = cnt_q + 1'b1;
        if (cnt_end) begin
          cnt_d = '0;
          sclk_d = 1'b0;
          tx_d = {tx_q[`DRL_MAIN_FRAME_LEN-2:0], 1'b0};
          bits_d = bits_q - 1'b1;
          if (bits_q == 5'h01) begin
            st_d = DRL_STB_WAIT;
          end else begin
            st_d = DRL_SETUP;
          end
        end
      end
      DRL_STB_WAIT: begin
        // strobe rises well after the last edge
        cnt_d = cnt_q + 1'b1;
        if (cnt_end) begin
          cnt_d = '0;
          stb_d = 1'b1;
          st_d = DRL_STROBE;
        end
      end
      DRL_STROBE: begin
        // strobe held high for the minimum width
        cnt_d = cnt_q + 1'b1;
        if (cnt_end) begin
          cnt_d = '0;
          stb_d = 1'b0;
          // record which divider is now defined
          if (tgt_q == `DRL_CTRL_REF) begin
            ref_done_d = 1'b1;
          end else begin
            main_done_d = 1'b1;
          end
          st_d = DRL_GAP;
        end
      end
      DRL_GAP: begin
        // quiet gap before the next frame starts
        cnt_d = cnt_q + 1'b1;
        if (cnt_end) begin
          cnt_d = '0;
          st_d = DRL_IDLE;
        end
      end
      default: begin
        st_d = DRL_IDLE;
      end
    endcase
  end

  // read path: one wait cycle, then registered data
  always_comb begin
    rd_ack_d = avs_read & ~rd_ack_q;
    rdata_d = rdata_q;
    if (avs_read & ~rd_ack_q) begin
      rdata_d = 32'h00000000;
      if (avs_address == `DRL_REG_REF) begin
        rdata_d[`DRL_REF_W-1:0] = ref_q;
      end else if (avs_address == `DRL_REG_MAIN) begin
        rdata_d[`DRL_SW_LSB +: `DRL_SWALLOW_W] = sw_q;
        rdata_d[`DRL_MAIN_LSB +: `DRL_MAIN_W] = main_q;
      end else if (avs_address == `DRL_REG_STATUS) begin
        rdata_d[`DRL_ST_BUSY] = busy;
        rdata_d[`DRL_ST_REF_DONE] = ref_done_q;
        rdata_d[`DRL_ST_MAIN_DONE] = main_done_q;
        rdata_d[`DRL_ST_ERR] = err_q;
        // ready only once both dividers were loaded
        rdata_d[`DRL_ST_READY] = ref_done_q & main_done_q;
      end
    end
  end

  // register all state, frozen while clk_en is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= DRL_IDLE;
      cnt_q <= 8'h00;
      tx_q <= 19'h00000;
      bits_q <= 5'h00;
      tgt_q <= 1'b0;
      sclk_q <= 1'b0;
      stb_q <= 1'b0;
      ref_q <= 14'h0000;
      sw_q <= 6'h00;
      main_q <= 12'h000;
      ref_done_q <= 1'b0;
      main_done_q <= 1'b0;
      err_q <= 1'b0;
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      bits_q <= bits_d;
      tgt_q <= tgt_d;
      sclk_q <= sclk_d;
      stb_q <= stb_d;
      ref_q <= ref_d;
      sw_q <= sw_d;
      main_q <= main_d;
      ref_done_q <= ref_done_d;
      main_done_q <= main_done_d;
      err_q <= err_d;
      rd_ack_q <= rd_ack_d;
      rdata_q <= rdata_d;
    end
  end

  // link pins and bus data, all from flops
  assign link.ser_data = tx_q[`DRL_MAIN_FRAME_LEN-1];
  assign link.ser_clk = sclk_q;
  assign link.latch_strobe = stb_q;
  assign avs_readdata = rdata_q;

endmodule

// ---- verification/drl_link_assertions.sv ----
// wire-level checker for the serial load link between host and device
`timescale 1ns/1ps
module drl_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link wires
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic latch_strobe
);
  logic [7:0] lo_q, hi_q, stab_q, stb_q;
  logic [4:0] bits_q;
  logic last_q, data_q;
  logic rise;
  assign rise = ser_clk && hi_q == 8'h00;
  // run lengths of clock low, clock high, stable data, strobe high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {lo_q, hi_q, stab_q, stb_q, bits_q, last_q, data_q} <= '0;
    end else begin
      lo_q <= ser_clk ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
      hi_q <= !ser_clk ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
      // a change is seen one edge after it was launched, so it has stood one cycle already
      stab_q <= (ser_data != data_q) ? 8'h01 : stab_q + {7'h00, stab_q != 8'hFF};
      stb_q <= !latch_strobe ? 8'h00 : stb_q + {7'h00, stb_q != 8'hFF};
      data_q <= ser_data;
      if (latch_strobe) begin
        bits_q <= 5'h00;
      end else if (rise) begin
        bits_q <= bits_q + 5'h01;
        last_q <= ser_data;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_clk_low_width: assert property (rise |-> lo_q >= 8'd200)
    else $error("serial clock low phase too short");
  a_clk_high_width: assert property (!ser_clk && lo_q == 8'h00 && hi_q != 8'h00 |-> hi_q >= 8'd200)
    else $error("serial clock high phase too short");
  a_data_setup_time: assert property (rise |-> stab_q >= 8'd200)
    else $error("data changed too close to clock rise");
  a_data_hold_high: assert property (ser_clk && hi_q != 8'h00 |-> $stable(ser_data))
    else $error("data changed while clock high");
  a_strobe_setup_time: assert property ($rose(latch_strobe) |-> !ser_clk && lo_q >= 8'd200)
    else $error("strobe raised too soon after last clock");
  a_strobe_min_width: assert property ($fell(latch_strobe) |-> stb_q >= 8'd200)
    else $error("strobe pulse too short");
  a_strobe_ends_bounded: assert property ($rose(latch_strobe) |-> ##[200:400] !latch_strobe)
    else $error("strobe stuck high");
  a_frame_bit_count: assert property ($rose(latch_strobe) |-> bits_q == 5'd15 || bits_q == 5'd19)
    else $error("frame length wrong");
  a_ref_ctrl_last: assert property ($rose(latch_strobe) && bits_q == 5'd15 |-> last_q)
    else $error("reference frame control bit not one");
  a_main_ctrl_last: assert property ($rose(latch_strobe) && bits_q == 5'd19 |-> !last_q)
    else $error("main frame control bit not zero");
  a_clock_still_strobe: assert property (latch_strobe |-> !ser_clk)
    else $error("clock moved during strobe");
  c_ref_frame: cover property ($rose(latch_strobe) && bits_q == 5'd15);
  c_main_frame: cover property ($rose(latch_strobe) && bits_q == 5'd19);
  c_clock_rise: cover property (rise);
endmodule

// ---- verification/divider_ratio_serial_loader_tb.sv ----
// self-checking bench: host and device back to back, plus a hand-driven link
`timescale 1ns/1ps
`include "drl_cfg.svh"
module divider_ratio_serial_loader_tb;
  import drl_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  drl_ref_t ref_a, ref_b;
  drl_swallow_t sw_a, sw_b;
  drl_main_t mn_a, mn_b;
  logic rl_a, ml_a, ok_a, ok_b;
  logic [31:0] rd;
  logic [18:0] sh = 19'h0;
  int edges = 0;
  int err_total = 0;
  int comparisons = 0;
  drl_if link();
  drl_if link_b();
  // 200 MHz clock
  always #2.5 clk = ~clk;
  drl_host drl_host_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link.host));
  drl_device drl_device_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .link(link.dev),
    .reference_ratio_bits(ref_a), .swallow_count_bits(sw_a), .main_count_bits(mn_a),
    .ref_loaded(rl_a), .main_loaded(ml_a), .ref_ratio_ok(ok_a));
  drl_device drl_device_inst2 (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .link(link_b.dev),
    .reference_ratio_bits(ref_b), .swallow_count_bits(sw_b), .main_count_bits(mn_b),
    .ref_loaded(), .main_loaded(), .ref_ratio_ok(ok_b));
  drl_link_assertions drl_link_assertions_inst (.clk(clk), .reset_n(reset_n), .ser_data(link.ser_data),
    .ser_clk(link.ser_clk), .latch_strobe(link.latch_strobe));
  // capture of each frame on the wire, first bit first
  always @(posedge link.ser_clk) begin
    sh <= {sh[17:0], link.ser_data};
    edges <= edges + 1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20000);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    if (n >= 20000) begin
      err_total++;
      print_verdict;
    end
  endtask
  // poll status until the sequencer is idle
  task wait_idle;
    int n;
    n = 0;
    do begin
      av(1'b0, `DRL_REG_STATUS, 32'h0);
      n++;
    end while (rd[`DRL_ST_BUSY] !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      err_total++;
      print_verdict;
    end
  endtask
  // hand-driven frame of n bits, 48 ns link clock, strobe after 1 us
  task bang(input logic [21:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_b.ser_data <= b[i];
      #24 link_b.ser_clk <= 1'b1;
      #24 link_b.ser_clk <= 1'b0;
    end
    link_b.ser_data <= ~b[0];  // released line shows the inverse
    repeat (200) @(posedge clk);
    link_b.latch_strobe <= 1'b1;
    repeat (200) @(posedge clk);
    link_b.latch_strobe <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // main sequence
  initial begin
    link_b.ser_data = 1'b0;
    link_b.ser_clk = 1'b0;
    link_b.latch_strobe = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk({rl_a, ml_a}, 2'b00);
    $display("test reset done");
    edges = 0;
    av(1'b1, `DRL_REG_REF, 32'h5);
    wait_idle;
    chk(ref_a, 14'h5);
    chk({rl_a, ml_a, ok_a}, 3'b101);
    chk(edges, 15);
    chk(sh[14:0], {14'h5, 1'b1});
    chk(rd[4:0], 5'h02);
    $display("test reference load done");
    edges = 0;
    av(1'b1, `DRL_REG_MAIN, {14'h0, 12'h5, 6'h4});
    wait_idle;
    chk({mn_a, sw_a}, {12'h5, 6'h4});
    chk(ref_a, 14'h5);
    chk(edges, 19);
    chk(sh, {12'h5, 6'h4, 1'b0});
    $display("test main load done");
    av(1'b1, `DRL_REG_REF, 32'h3FFF);
    av(1'b1, `DRL_REG_MAIN, {14'h0, 12'hFFF, 6'h3F});
    wait_idle;
    chk(ref_a, 14'h3FFF);
    chk({mn_a, sw_a}, {12'hFFF, 6'h3F});
    chk(rd[4:0], 5'h16);
    av(1'b0, `DRL_REG_REF, 32'h0);
    chk(rd, 32'h00003FFF);
    av(1'b0, `DRL_REG_MAIN, 32'h0);
    chk(rd, {14'h0, 12'hFFF, 6'h3F});
    $display("test back to back done");
    av(1'b1, `DRL_REG_REF, 32'h4);
    av(1'b0, `DRL_REG_STATUS, 32'h0);
    chk(rd[`DRL_ST_ERR], 1'b1);
    av(1'b1, `DRL_REG_MAIN, {14'h0, 12'h5, 6'h5});
    av(1'b0, `DRL_REG_STATUS, 32'h0);
    chk(rd[`DRL_ST_ERR], 1'b1);
    chk(rd[`DRL_ST_BUSY], 1'b0);
    chk({ref_a, mn_a}, {14'h3FFF, 12'hFFF});
    av(1'b0, 2'h3, 32'h0);
    chk(rd, 32'h0);
    $display("test refusals done");
    // freeze mid-frame: link clock and dividers hold, bus stalls
    av(1'b1, `DRL_REG_REF, 32'h1234);
    clk_en <= 1'b0;
    repeat (250) @(posedge clk);
    chk({avs_waitrequest, link.ser_clk, ref_a}, {1'b1, 1'b0, 14'h3FFF});
    clk_en <= 1'b1;
    wait_idle;
    chk(ref_a, 14'h1234);
    $display("test clock enable freeze done");
    bang({5'h0, 2'b10, 14'h2ABC, 1'b1}, 17);
    chk(ref_b, 14'h2ABC);
    bang({3'b101, 12'h123, 6'h2A, 1'b0}, 22);
    chk({mn_b, sw_b}, {12'h123, 6'h2A});
    chk(ref_b, 14'h2ABC);
    bang({7'h0, 14'h4, 1'b1}, 15);
    chk({ok_b, ref_b}, {1'b0, 14'h4});
    chk({mn_b, sw_b}, {12'h123, 6'h2A});
    $display("test overlong frames done");
    print_verdict;
  end
endmodule
